// ==== hw/snpc_pkg.sv ====
// Constants for the serial network module pin-control block.
// Assumes a single 40 MHz system clock and synchronous pin inputs.
// Overview of operation
// - Reset pin held low 200 ms resets module
// - TCP mode: indicator low while connected and not in module reset
// - UDP mode: indicator low except during module reset
// - Line driver enable high while sending
// - Serial data out on tx, in on rx
// - Configuration guide pin has no effect
// - Baud rate programmable 300 to 921600
// - Packet closes after 4 idle bytes or 400
package snpc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 40000000;
    localparam int RESET_HOLD_MS = 200;
    localparam int RESET_HOLD_CYCLES = (CLK_HZ / 1000) * RESET_HOLD_MS;
    localparam int BAUD_MIN = 300;
    localparam int BAUD_MAX = 921600;
    localparam int BAUD_RESET = 115200;
    localparam int BAUD_DIV_RESET = CLK_HZ / BAUD_RESET;
    localparam int BAUD_DIV_MIN = CLK_HZ / BAUD_MAX;
    localparam int BAUD_DIV_MAX = CLK_HZ / BAUD_MIN;

    // ------------------------------------------------------------
    // Packing
    // ------------------------------------------------------------
    localparam int PACK_IDLE_BYTES = 4;
    localparam int PACK_MAX_BYTES = 400;
    localparam int BITS_PER_FRAME = 10;

    typedef enum logic [1:0] {
        SNPC_TX_IDLE = 2'b00,
        SNPC_TX_SHIFT = 2'b01,
        SNPC_TX_STOP = 2'b10
    } snpc_tx_state_t;

    function automatic logic [17:0] snpc_clamp_div(input logic [17:0] div);
        if (div < 18'(BAUD_DIV_MIN))
            return 18'(BAUD_DIV_MIN);
        else if (div > 18'(BAUD_DIV_MAX))
            return 18'(BAUD_DIV_MAX);
        else
            return div;
    endfunction : snpc_clamp_div

endpackage : snpc_pkg

// ==== hw/snpc_uart_rx.sv ====
// Serial receiver of the pin-control block.
// Assumes rx_in is synchronous to clk_sys_in and idles high.
`timescale 1ns/1ps
module snpc_uart_rx (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Configuration
    input wire logic [17:0] baud_div_in,
    // Serial pin
    input wire logic rx_in,
    // Received byte
    output logic [7:0] data_out,
    output logic valid_out
);

    logic [17:0] cnt;
    logic [3:0] bit_idx;
    logic busy;
    logic [7:0] shreg;

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            cnt <= 18'h00000;
            bit_idx <= 4'h0;
            busy <= 1'b0;
            shreg <= 8'h00;
            data_out <= 8'h00;
            valid_out <= 1'b0;
        end
        else
        begin
            valid_out <= 1'b0;
            if (!busy)
            begin
                if (!rx_in)
                begin
                    busy <= 1'b1;
                    cnt <= baud_div_in >> 1;
                    bit_idx <= 4'h0;
                end
            end
            else if (cnt != 18'h00000)
                cnt <= cnt - 18'h00001;
            else
            begin
                cnt <= baud_div_in - 18'h00001;
                bit_idx <= bit_idx + 4'h1;
                if (bit_idx == 4'h0 && rx_in)
                    busy <= 1'b0;
                else if (bit_idx >= 4'h1 && bit_idx <= 4'h8)
                    shreg <= {rx_in, shreg[7:1]};
                else if (bit_idx == 4'h9)
                begin
                    busy <= 1'b0;
                    if (rx_in)
                    begin
                        data_out <= shreg;
                        valid_out <= 1'b1;
                    end
                end
            end
        end
    end

endmodule : snpc_uart_rx

// ==== hw/snpc_pin_ctrl.sv ====
// Pin-level control of the serial network module: reset filter, link
// indicator, line driver enable, serial transmit and receive packing.
// Assumes all inputs are synchronous to clk_sys_in.
`timescale 1ns/1ps
module snpc_pin_ctrl #(
    parameter int RESET_HOLD = snpc_pkg::RESET_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Module pins
    input wire logic reset_pin_n_in,
    input wire logic rx_in,
    input wire logic cfg_guide_in,
    output logic tx_out,
    output logic link_n_out,
    output logic line_driver_tx_enable_out,
    // Network side status and configuration
    input wire logic udp_mode_in,
    input wire logic connected_in,
    input wire logic [17:0] baud_div_in,
    // Network to serial byte stream
    input wire logic [7:0] net_data_in,
    input wire logic net_valid_in,
    output logic net_ready_out,
    // Serial to network packets
    output logic [7:0] pkt_data_out,
    output logic pkt_valid_out,
    output logic pkt_last_out,
    // Module reset request
    output logic module_reset_out
);

    // ------------------------------------------------------------
    // Reset pin filter
    // ------------------------------------------------------------
    logic [31:0] low_cnt;
    logic soft_rst;

    // A low pulse only counts once it has lasted the whole hold time.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            low_cnt <= 32'h00000000;
            module_reset_out <= 1'b0;
        end
        else if (reset_pin_n_in)
        begin
            low_cnt <= 32'h00000000;
            module_reset_out <= 1'b0;
        end
        else if (low_cnt < 32'(RESET_HOLD - 1))
        begin
            low_cnt <= low_cnt + 32'h00000001;
            module_reset_out <= 1'b0;
        end
        else
            module_reset_out <= 1'b1;
    end

    assign soft_rst = module_reset_out;

    // ------------------------------------------------------------
    // Configuration and indicator
    // ------------------------------------------------------------
    logic [17:0] baud_div;

    // The divider follows its input every cycle; change it only between frames.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            baud_div <= 18'(snpc_pkg::BAUD_DIV_RESET);
        else
            baud_div <= snpc_pkg::snpc_clamp_div(baud_div_in);
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            link_n_out <= 1'b1;
        else if (soft_rst)
            link_n_out <= 1'b1;
        else if (udp_mode_in)
            link_n_out <= 1'b0;
        else
            link_n_out <= !connected_in;
    end

    // The configuration guide pin is deliberately left unread.
    logic unused_cfg;
    assign unused_cfg = cfg_guide_in;

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    snpc_pkg::snpc_tx_state_t tx_state;
    logic [17:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;

    assign net_ready_out = (tx_state == snpc_pkg::SNPC_TX_IDLE) && !soft_rst;

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            tx_state <= snpc_pkg::SNPC_TX_IDLE;
            tx_cnt <= 18'h00000;
            tx_bit <= 3'h0;
            tx_sh <= 8'h00;
            tx_out <= 1'b1;
            line_driver_tx_enable_out <= 1'b0;
        end
        else if (soft_rst)
        begin
            tx_state <= snpc_pkg::SNPC_TX_IDLE;
            tx_out <= 1'b1;
            line_driver_tx_enable_out <= 1'b0;
        end
        else
        begin
            unique case (tx_state)
                snpc_pkg::SNPC_TX_IDLE:
                begin
                    tx_out <= 1'b1;
                    line_driver_tx_enable_out <= 1'b0;
                    if (net_valid_in)
                    begin
                        tx_sh <= net_data_in;
                        tx_out <= 1'b0;
                        line_driver_tx_enable_out <= 1'b1;
                        tx_cnt <= baud_div - 18'h00001;
                        tx_bit <= 3'h0;
                        tx_state <= snpc_pkg::SNPC_TX_SHIFT;
                    end
                end
                snpc_pkg::SNPC_TX_SHIFT:
                begin
                    if (tx_cnt != 18'h00000)
                        tx_cnt <= tx_cnt - 18'h00001;
                    else
                    begin
                        tx_cnt <= baud_div - 18'h00001;
                        tx_out <= tx_sh[0];
                        tx_sh <= {1'b0, tx_sh[7:1]};
                        tx_bit <= tx_bit + 3'h1;
                        if (tx_bit == 3'h7)
                            tx_state <= snpc_pkg::SNPC_TX_STOP;
                    end
                end
                snpc_pkg::SNPC_TX_STOP:
                begin
                    if (tx_cnt != 18'h00000)
                        tx_cnt <= tx_cnt - 18'h00001;
                    else if (tx_bit == 3'h0)
                    begin
                        tx_out <= 1'b1;
                        tx_cnt <= baud_div - 18'h00001;
                        tx_bit <= 3'h1;
                    end
                    else
                        tx_state <= snpc_pkg::SNPC_TX_IDLE;
                end
                default:
                    tx_state <= snpc_pkg::SNPC_TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receiver and packing
    // ------------------------------------------------------------
    logic [7:0] rx_data;
    logic rx_valid;
    logic [31:0] idle_cnt;
    logic [8:0] pkt_cnt;
    logic [31:0] idle_limit;

    snpc_uart_rx u_rx (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .baud_div_in(baud_div),
        .rx_in(rx_in),
        .data_out(rx_data),
        .valid_out(rx_valid)
    );

    assign idle_limit = 32'(baud_div) * 32'(snpc_pkg::BITS_PER_FRAME * snpc_pkg::PACK_IDLE_BYTES);

    // Bytes are forwarded at once; the packet end is marked on the last byte when
    // the count closes it, or as a lone marker pulse when the line goes idle.
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            pkt_data_out <= 8'h00;
            pkt_valid_out <= 1'b0;
            pkt_last_out <= 1'b0;
            pkt_cnt <= 9'h000;
            idle_cnt <= 32'h00000000;
        end
        else
        begin
            pkt_valid_out <= 1'b0;
            pkt_last_out <= 1'b0;
            if (soft_rst)
            begin
                pkt_cnt <= 9'h000;
                idle_cnt <= 32'h00000000;
            end
            else if (rx_valid)
            begin
                pkt_data_out <= rx_data;
                pkt_valid_out <= 1'b1;
                idle_cnt <= 32'h00000000;
                if (pkt_cnt == 9'(snpc_pkg::PACK_MAX_BYTES - 1))
                begin
                    pkt_last_out <= 1'b1;
                    pkt_cnt <= 9'h000;
                end
                else
                    pkt_cnt <= pkt_cnt + 9'h001;
            end
            else if (pkt_cnt != 9'h000)
            begin
                if (idle_cnt >= idle_limit)
                begin
                    pkt_last_out <= 1'b1;
                    pkt_cnt <= 9'h000;
                    idle_cnt <= 32'h00000000;
                end
                else
                    idle_cnt <= idle_cnt + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_udp_low;
        @(posedge clk_sys_in) disable iff (reset_in)
        (udp_mode_in && !soft_rst) |=> !link_n_out;
    endproperty
    a_udp_low: assert property (p_udp_low) else $error("udp indicator not low");

    property p_tcp_follow;
        @(posedge clk_sys_in) disable iff (reset_in)
        (!udp_mode_in && !soft_rst) |=> (link_n_out == !$past(connected_in));
    endproperty
    a_tcp_follow: assert property (p_tcp_follow) else $error("tcp indicator wrong");

    property p_short_ignored;
        @(posedge clk_sys_in) disable iff (reset_in)
        $rose(module_reset_out) |-> (low_cnt == 32'(RESET_HOLD - 1));
    endproperty
    a_short_ignored: assert property (p_short_ignored) else $error("early reset");

    property p_reset_hold;
        @(posedge clk_sys_in) disable iff (reset_in)
        (!reset_pin_n_in && low_cnt == 32'(RESET_HOLD - 1)) |=> module_reset_out;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("hold reset missed");

    property p_release;
        @(posedge clk_sys_in) disable iff (reset_in)
        reset_pin_n_in |=> !module_reset_out;
    endproperty
    a_release: assert property (p_release) else $error("reset not released");

    property p_driver_en;
        @(posedge clk_sys_in) disable iff (reset_in)
        (tx_state != snpc_pkg::SNPC_TX_IDLE) |-> line_driver_tx_enable_out;
    endproperty
    a_driver_en: assert property (p_driver_en) else $error("driver off while sending");

    property p_start_bit;
        @(posedge clk_sys_in) disable iff (reset_in)
        (net_valid_in && net_ready_out) |=> (!tx_out && line_driver_tx_enable_out);
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");

    property p_max_len;
        @(posedge clk_sys_in) disable iff (reset_in)
        pkt_cnt < 9'(snpc_pkg::PACK_MAX_BYTES);
    endproperty
    a_max_len: assert property (p_max_len) else $error("packet over length");

    property p_baud_range;
        @(posedge clk_sys_in) disable iff (reset_in)
        (baud_div >= 18'(snpc_pkg::BAUD_DIV_MIN)) && (baud_div <= 18'(snpc_pkg::BAUD_DIV_MAX));
    endproperty
    a_baud_range: assert property (p_baud_range) else $error("divider out of range");

endmodule : snpc_pin_ctrl

// ==== bench/snpc_host_model.sv ====
// Host model: drives the module reset pin and the serial receive pin,
// and decodes the serial transmit pin. Assumes 8N1 framing at BIT clocks per bit.
`timescale 1ns/1ps
module snpc_host_model #(
    parameter int BIT = 43
) (
    // Clock
    input wire logic clk_sys_in,
    // Module pins
    input wire logic tx_in,
    output logic rx_out,
    output logic reset_pin_n_out,
    // Decoded bytes
    output logic [7:0] got_out,
    output int got_cnt_out
);
    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    initial
    begin
        rx_out = 1'b1;
        reset_pin_n_out = 1'b1;
        got_out = 8'h00;
        got_cnt_out = 0;
    end

    // Called at a falling edge; holds the pin low for n cycles.
    task automatic hold_reset(input int n);
        reset_pin_n_out = 1'b0;
        repeat (n) @(negedge clk_sys_in);
        reset_pin_n_out = 1'b1;
    endtask : hold_reset

    task automatic send_byte(input logic [7:0] d);
        logic [9:0] frame;
        frame = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_out = frame[i];
            repeat (BIT) @(negedge clk_sys_in);
        end
    endtask : send_byte

    // ------------------------------------------------------------
    // Decoder
    // ------------------------------------------------------------
    // Samples near mid-bit so that a small phase offset still decodes.
    always
    begin : decode
        logic [7:0] b;
        @(negedge clk_sys_in iff tx_in === 1'b0);
        repeat (BIT / 2) @(negedge clk_sys_in);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(negedge clk_sys_in);
            b[i] = tx_in;
        end
        repeat (BIT) @(negedge clk_sys_in);
        if (tx_in === 1'b1)
        begin
            got_out = b;
            got_cnt_out++;
        end
    end
endmodule : snpc_host_model

// ==== bench/tb.sv ====
// Self-checking bench of the pin-control block with a host model.
// Assumes a shortened reset hold of 20 cycles and 43 clocks per bit.
`timescale 1ns/1ps
module tb;
    logic clk_sys_in, reset_in, rx_in, cfg_guide_in, tx_out, link_n_out, drv_en;
    logic udp_mode_in, connected_in, net_valid_in, net_ready_out;
    logic pkt_valid_out, pkt_last_out, module_reset_out, reset_pin_n;
    logic [17:0] baud_div_in;
    logic [7:0] net_data_in, pkt_data_out, got, q[$];
    logic [15:0] seed;
    int got_cnt, failures, n_checks, lone_last, t;

    snpc_pin_ctrl #(.RESET_HOLD(20)) dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .reset_pin_n_in(reset_pin_n), .rx_in(rx_in), .cfg_guide_in(cfg_guide_in),
        .tx_out(tx_out), .link_n_out(link_n_out), .line_driver_tx_enable_out(drv_en),
        .udp_mode_in(udp_mode_in), .connected_in(connected_in), .baud_div_in(baud_div_in),
        .net_data_in(net_data_in), .net_valid_in(net_valid_in),
        .net_ready_out(net_ready_out), .pkt_data_out(pkt_data_out),
        .pkt_valid_out(pkt_valid_out), .pkt_last_out(pkt_last_out),
        .module_reset_out(module_reset_out));
    snpc_host_model #(.BIT(43)) host (.clk_sys_in(clk_sys_in), .tx_in(tx_out),
        .rx_out(rx_in), .reset_pin_n_out(reset_pin_n), .got_out(got),
        .got_cnt_out(got_cnt));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic exp_link(input logic udp, input logic conn);
        return udp ? 1'b0 : !conn;
    endfunction : exp_link

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // Registered outputs are read before this edge's updates land.
    always @(posedge clk_sys_in)
    begin
        if (pkt_valid_out === 1'b1)
            q.push_back(pkt_data_out);
        else if (pkt_last_out === 1'b1)
            lone_last++;
    end

    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial
    begin
        reset_in = 1'b1;
        cfg_guide_in = 1'b0;
        udp_mode_in = 1'b0;
        connected_in = 1'b0;
        baud_div_in = 18'h0002b;
        net_data_in = 8'h00;
        net_valid_in = 1'b0;
        seed = 16'h0040;
        failures = 0;
        n_checks = 0;
        lone_last = 0;
        repeat (12) @(negedge clk_sys_in);
        reset_in = 1'b0;
        for (int i = 0; i < 20; i++)
        begin
            seed = lfsr(seed);
            {cfg_guide_in, connected_in, udp_mode_in} = seed[2:0];
            repeat (2) @(negedge clk_sys_in);
            check(8'(link_n_out), 8'(exp_link(udp_mode_in, connected_in)));
            check(8'(drv_en), 8'h00);
        end
        $display("test link done");
        // The first divider is below the minimum and must be clamped.
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            baud_div_in = (k == 0) ? 18'h0000a : 18'h0002b;
            net_data_in = (k == 1) ? 8'hff : seed[7:0];
            net_valid_in = 1'b1;
            t = got_cnt;
            for (int w = 0; w < 1000 && net_ready_out !== 1'b1; w++) @(negedge clk_sys_in);
            @(negedge clk_sys_in);
            net_valid_in = 1'b0;
            check(8'(drv_en), 8'h01);
            check(8'(net_ready_out), 8'h00);
            for (int w = 0; w < 1000 && got_cnt == t; w++) @(negedge clk_sys_in);
            check(got, net_data_in);
            // The stop bit is still on the line here, so the driver must stay on.
            check(8'(drv_en), 8'h01);
            check(8'(net_ready_out), 8'h00);
        end
        repeat (60) @(negedge clk_sys_in);
        check(8'(drv_en), 8'h00);
        check(8'(tx_out), 8'h01);
        $display("test transmit done");
        for (int k = 0; k < 3; k++)
        begin
            seed = lfsr(seed);
            host.send_byte(seed[7:0]);
        end
        repeat (1900) @(negedge clk_sys_in);
        check(8'(q.size()), 8'h03);
        seed = 16'h0040;
        for (int k = 0; k < 20 + 4 + 3; k++)
        begin
            seed = lfsr(seed);
            if (k >= 24 && q.size() > 0)
                check(q.pop_front(), seed[7:0]);
        end
        check(8'(lone_last), 8'h01);
        $display("test receive done");
        udp_mode_in = 1'b0;
        connected_in = 1'b1;
        host.hold_reset(10);
        repeat (5) @(negedge clk_sys_in);
        check(8'(module_reset_out), 8'h00);
        check(8'(link_n_out), 8'h00);
        fork
            host.hold_reset(30);
        join_none
        repeat (18) @(negedge clk_sys_in);
        check(8'(module_reset_out), 8'h00);
        repeat (5) @(negedge clk_sys_in);
        check(8'(module_reset_out), 8'h01);
        check(8'(link_n_out), 8'h01);
        check(8'(net_ready_out), 8'h00);
        repeat (10) @(negedge clk_sys_in);
        check(8'(module_reset_out), 8'h00);
        check(8'(link_n_out), 8'h00);
        $display("test reset pin done");
        report_and_stop();
    end
endmodule : tb
